// >>> design/fpe_erase.sv
// Purpose: page-erase sequencer for the embedded flash block
// Assumes: request inputs come from fabric logic on i_clk_sys
// Notes:   one erase at a time; request must drop before the next
// How it works
// - request plus address starts a page erase
// - successful erase zeroes the page's user data
// - guard inputs act as in page program
// - status 01 means page left unerased
// - overwrite-protected page refused, status 01
// - loss-guard mode refuses other pages, status 01
// - write count over threshold gives status 11
// - uncorrectable ECC error gives status 10
// - 64 sectors of 32 pages plus spare
// - spare select ignores page address bits
`timescale 1ns/1ps
`include "fpe_map.svh"

module fpe_erase (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_reset,
  input  fpe_pkg::fpe_req_s          i_req,
  input  wire logic                  i_buf_dirty,
  input  wire logic [`FPE_IDX_W-1:0] i_buf_index,
  input  fpe_pkg::fpe_load_s         i_load,
  input  wire logic [`FPE_IDX_W-1:0] i_peek_index,
  output fpe_pkg::fpe_rec_s          o_peek,
  output logic                       o_busy,
  output logic                       o_done,
  output logic [1:0]                 o_status
);

  fpe_pkg::fpe_state_e   state_q;
  fpe_pkg::fpe_state_e   state_d;
  fpe_pkg::fpe_req_s     req_q;
  fpe_pkg::fpe_rec_s     rd_rec;
  fpe_pkg::fpe_rec_s     wr_rec;
  logic [`FPE_IDX_W-1:0] req_idx;
  logic [`FPE_IDX_W-1:0] idx_q;
  logic [`FPE_IDX_W-1:0] wr_idx;
  logic [5:0]            slot;
  logic                  take;
  logic                  loss_mode;
  logic                  spare0;
  logic                  refused;
  logic                  worn;
  logic                  eng_we;
  logic                  mem_we;
  logic [1:0]            status_q;
  logic [1:0]            status_d;

  // ----------------------------------------------------------------
  // address to page index
  // ----------------------------------------------------------------
  // index = sector * 33 + slot, slot 32 is the spare page
  always_comb
  begin
    slot = i_req.extra_page_select ? `FPE_SPARE_SLOT
         : {1'b0, i_req.addr[`FPE_PG_HI:`FPE_PG_LO]};
    req_idx = {1'b0, i_req.addr[`FPE_SEC_HI:`FPE_SEC_LO], 5'h00}
            + {6'h00, i_req.addr[`FPE_SEC_HI:`FPE_SEC_LO]}
            + {6'h00, slot};
  end

  assign take = (state_q == fpe_pkg::FPE_IDLE) && i_req.page_clear_request;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      fpe_pkg::FPE_IDLE:
      begin
        if (take)
        begin
          state_d = fpe_pkg::FPE_FETCH;
        end
      end
      fpe_pkg::FPE_FETCH:
      begin
        state_d = fpe_pkg::FPE_DONE;
      end
      fpe_pkg::FPE_DONE:
      begin
        state_d = fpe_pkg::FPE_RELEASE;
      end
      default:
      begin
        // a held request must not launch a second erase
        if (!i_req.page_clear_request)
        begin
          state_d = fpe_pkg::FPE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state_q <= fpe_pkg::FPE_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      req_q <= '0;
      idx_q <= '0;
    end
    else if (take)
    begin
      req_q <= i_req;
      idx_q <= req_idx;
    end
  end

  // ----------------------------------------------------------------
  // judgement on the fetched record
  // ----------------------------------------------------------------
  always_comb
  begin
    // guard taken from the request, as a page program would
    loss_mode = i_buf_dirty && req_q.buffer_loss_guard;
    spare0    = req_q.extra_page_select
              && (req_q.addr[`FPE_SEC_HI:`FPE_SEC_LO] == 6'h00);
    refused   = rd_rec.protect
              || (loss_mode && (idx_q != i_buf_index))
              || spare0;
    worn      = rd_rec.wcount > `FPE_WRITE_THRESH;
    eng_we    = (state_q == fpe_pkg::FPE_FETCH) && !refused;
    if (refused)
    begin
      status_d = `FPE_ST_REFUSED;
    end
    else if (rd_rec.ecc_bad)
    begin
      status_d = `FPE_ST_ECC;
    end
    else if (worn)
    begin
      status_d = `FPE_ST_WEAR;
    end
    else
    begin
      status_d = `FPE_ST_OK;
    end
  end

  always_comb
  begin
    wr_rec         = i_load.rec;
    wr_idx         = i_load.index;
    mem_we         = i_load.valid && (state_q == fpe_pkg::FPE_IDLE) && !take;
    if (eng_we)
    begin
      wr_rec.data    = '0;
      wr_rec.ecc_bad = 1'b0;
      wr_rec.protect = req_q.rewrite_guard_enable;
      wr_rec.wcount  = (rd_rec.wcount == `FPE_WCOUNT_MAX) ? rd_rec.wcount
                     : rd_rec.wcount + 16'h0001;
      wr_idx         = idx_q;
      mem_we         = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      status_q <= `FPE_ST_OK;
    end
    else if (state_q == fpe_pkg::FPE_FETCH)
    begin
      status_q <= status_d;
    end
  end

  fpe_page_store u_store (
    .i_clk_sys  (i_clk_sys),
    .i_reset    (i_reset),
    .i_we       (mem_we),
    .i_wr_index (wr_idx),
    .i_wr_rec   (wr_rec),
    .i_rd_index (req_idx),
    .o_rd_rec   (rd_rec),
    .i_pk_index (i_peek_index),
    .o_pk_rec   (o_peek)
  );

  assign o_busy   = (state_q == fpe_pkg::FPE_FETCH) || (state_q == fpe_pkg::FPE_DONE);
  assign o_done   = (state_q == fpe_pkg::FPE_DONE);
  assign o_status = status_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  start_to_done_a: assert property (take |-> ##2 o_done)
    else $error("erase did not complete two cycles after start");
  zero_data_a: assert property (o_done && o_status != 2'h1
    |-> $past(mem_we) && $past(wr_rec.data) == '0)
    else $error("successful erase did not zero the page data");
  guard_copy_a: assert property (eng_we
    |-> wr_rec.protect == req_q.rewrite_guard_enable)
    else $error("rewrite guard not applied to erased page");
  refused_nowrite_a: assert property ((state_q == fpe_pkg::FPE_FETCH)
    && refused |-> !mem_we ##1 (o_done && o_status == 2'h1))
    else $error("refused page was written or misreported");
  protect_refuse_a: assert property ((state_q == fpe_pkg::FPE_FETCH)
    && rd_rec.protect |=> (o_status == 2'h1) [*2])
    else $error("protected page not refused");
  loss_refuse_a: assert property ((state_q == fpe_pkg::FPE_FETCH)
    && i_buf_dirty && req_q.buffer_loss_guard && idx_q != i_buf_index
    |=> o_status == 2'h1)
    else $error("loss guard did not refuse foreign page");
  wear_status_a: assert property ((state_q == fpe_pkg::FPE_FETCH)
    && !refused && !rd_rec.ecc_bad && rd_rec.wcount > `FPE_WRITE_THRESH
    |=> o_done && o_status == 2'h3)
    else $error("worn page not reported");
  ecc_status_a: assert property ((state_q == fpe_pkg::FPE_FETCH)
    && !refused && rd_rec.ecc_bad |=> o_status == 2'h2)
    else $error("ecc error not reported");
  index_range_a: assert property (take |-> req_idx < `FPE_DEPTH)
    else $error("page index out of range");
  spare_index_a: assert property (take && i_req.extra_page_select
    |-> req_idx == ({1'b0, i_req.addr[`FPE_SEC_HI:`FPE_SEC_LO], 5'h00}
    + {6'h00, i_req.addr[`FPE_SEC_HI:`FPE_SEC_LO]} + 12'h020))
    else $error("spare page index wrong");
  hold_release_a: assert property (o_done && i_req.page_clear_request
    |=> !o_busy throughout (!o_done [*2]))
    else $error("held request relaunched an erase");

  erase_ok_c: cover property (o_done && o_status == 2'h0);
  erase_refused_c: cover property (o_done && o_status == 2'h1);
  erase_ecc_c: cover property (o_done && o_status == 2'h2);
  erase_worn_c: cover property (o_done && o_status == 2'h3);

endmodule // fpe_erase

// >>> include/fpe_map.svh
// Purpose: constants for the flash page-erase block
// Assumes: included by its bare name wherever a define is used
// Notes:   offsets, field positions, codes and limits live here
`ifndef FPE_MAP_SVH
`define FPE_MAP_SVH

// ----------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------
`define FPE_SECTORS      64
`define FPE_PAGES        32
`define FPE_SLOTS        33
`define FPE_DEPTH        2112
`define FPE_ADDR_W       18
`define FPE_IDX_W        12
`define FPE_SEC_HI       17
`define FPE_SEC_LO       12
`define FPE_PG_HI        11
`define FPE_PG_LO        7
`define FPE_SPARE_SLOT   6'h20

// ----------------------------------------------------------------
// page record and status codes
// ----------------------------------------------------------------
`define FPE_WCOUNT_W     16
`define FPE_DATA_W       32
`define FPE_WCOUNT_MAX   16'hFFFF
`define FPE_WRITE_THRESH 16'h1000
`define FPE_ST_OK        2'h0
`define FPE_ST_REFUSED   2'h1
`define FPE_ST_ECC       2'h2
`define FPE_ST_WEAR      2'h3

`endif

// >>> include/fpe_pkg.sv
// Purpose: types shared by the page-erase engine and its page store
// Assumes: fpe_map.svh on the include path
// Notes:   numbers stay in the map header, types live here
`include "fpe_map.svh"

package fpe_pkg;

  // ----------------------------------------------------------------
  // request from fabric logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                   page_clear_request;
    logic                   rewrite_guard_enable;
    logic                   buffer_loss_guard;
    logic                   extra_page_select;
    logic [`FPE_ADDR_W-1:0] addr;
  } fpe_req_s;

  // ----------------------------------------------------------------
  // per-page record held by the store
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                     protect;
    logic                     ecc_bad;
    logic [`FPE_WCOUNT_W-1:0] wcount;
    logic [`FPE_DATA_W-1:0]   data;
  } fpe_rec_s;

  typedef struct packed {
    logic                  valid;
    logic [`FPE_IDX_W-1:0] index;
    fpe_rec_s              rec;
  } fpe_load_s;

  typedef enum logic [1:0] {
    FPE_IDLE,
    FPE_FETCH,
    FPE_DONE,
    FPE_RELEASE
  } fpe_state_e;

endpackage

// >>> design/fpe_page_store.sv
// Purpose: page record memory for the flash block
// Assumes: one write port, two registered read ports
// Notes:   contents are not reset; pages must be loaded before use
`timescale 1ns/1ps
`include "fpe_map.svh"

module fpe_page_store (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_reset,
  input  wire logic                  i_we,
  input  wire logic [`FPE_IDX_W-1:0] i_wr_index,
  input  fpe_pkg::fpe_rec_s          i_wr_rec,
  input  wire logic [`FPE_IDX_W-1:0] i_rd_index,
  output fpe_pkg::fpe_rec_s          o_rd_rec,
  input  wire logic [`FPE_IDX_W-1:0] i_pk_index,
  output fpe_pkg::fpe_rec_s          o_pk_rec
);

  fpe_pkg::fpe_rec_s mem [0:`FPE_DEPTH-1];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (i_we)
    begin
      mem[i_wr_index] <= i_wr_rec;
    end
  end

  // ----------------------------------------------------------------
  // read registers, old data on a same-cycle write
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_rd_rec <= '0;
      o_pk_rec <= '0;
    end
    else
    begin
      o_rd_rec <= mem[i_rd_index];
      o_pk_rec <= mem[i_pk_index];
    end
  end

endmodule // fpe_page_store

// >>> bench/fpe_fabric_model.sv
// Purpose: fabric logic that issues page erases
// Assumes: same clock as the erase engine
// Notes:   released fields show inverted values, not the last ones
`timescale 1ns/1ps

module fpe_fabric_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_done,
  input  wire logic [1:0]  i_status,
  output fpe_pkg::fpe_req_s o_req
);
  initial o_req = '0;

  task automatic erase(input fpe_pkg::fpe_req_s r, input int hold, output logic [1:0] st,
                       output int lat);
    fpe_pkg::fpe_req_s rel;
    rel = ~r;
    rel.page_clear_request = 1'b0;
    lat = 0;
    @(posedge i_clk_sys);
    #1;
    o_req = r;
    do
    begin
      @(posedge i_clk_sys);
      lat++;
    end while (i_done !== 1'b1 && lat < 20);
    st = i_status;
    // a held request must not start a second erase
    repeat (hold) @(posedge i_clk_sys);
    #1;
    o_req = rel;
  endtask
endmodule // fpe_fabric_model

// >>> bench/flash_page_erase_test.sv
// Purpose: self-checking bench for the page-erase engine
// Assumes: fpe_map.svh on the include path
// Notes:   every page used is loaded first; store is not reset
`timescale 1ns/1ps
`include "fpe_map.svh"

module flash_page_erase_test;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              dirty = 1'b0;
  logic [11:0]       bidx = '0;
  logic [11:0]       pidx = '0;
  fpe_pkg::fpe_load_s ld = '0;
  fpe_pkg::fpe_req_s  req;
  fpe_pkg::fpe_rec_s  pk;
  logic              busy;
  logic              done;
  logic [1:0]        st;
  int                errors = 0;
  int                compares = 0;
  int                cycles = 0;

  fpe_erase u_dut (.i_clk_sys(clk), .i_reset(rst), .i_req(req), .i_buf_dirty(dirty),
    .i_buf_index(bidx), .i_load(ld), .i_peek_index(pidx), .o_peek(pk), .o_busy(busy),
    .o_done(done), .o_status(st));
  fpe_fabric_model u_fab (.i_clk_sys(clk), .i_done(done), .i_status(st), .o_req(req));

  initial forever #50 clk = ~clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic put(int i, fpe_pkg::fpe_rec_s r);
    @(posedge clk);
    #1;
    ld = '{1'b1, i[11:0], r};
    @(posedge clk);
    #1;
    ld.valid = 1'b0;
  endtask

  task automatic run(logic g, logic lg, logic sp, logic [17:0] a, logic [1:0] es, int i,
                     fpe_pkg::fpe_rec_s er);
    logic [1:0]        s;
    int                lat;
    fpe_pkg::fpe_rec_s r;
    u_fab.erase({1'b1, g, lg, sp, a}, 0, s, lat);
    chk("status", es, s);
    chk("latency", 3, lat);
    chk("busy and done after release", 2'h0, {busy, done});
    pidx = i[11:0];
    @(posedge clk);
    @(posedge clk);
    #1;
    r = pk;
    chk("record", er, r);
  endtask

  function automatic fpe_pkg::fpe_rec_s ers(logic g, logic [15:0] w);
    return '{g, 1'b0, w + 16'h0001, 32'h0};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_plain();
    put(36, '{1'b0, 1'b0, 16'h0005, 32'hA5A55A5A});
    run(1'b1, 1'b0, 1'b0, {6'h01, 5'h03, 7'h15}, 2'h0, 36, ers(1'b1, 16'h0005));
    $display("plain erase done");
  endtask

  task automatic t_prot();
    put(70, '{1'b1, 1'b0, 16'h0007, 32'h12345678});
    run(1'b0, 1'b0, 1'b0, {6'h02, 5'h04, 7'h00}, 2'h1, 70,
        '{1'b1, 1'b0, 16'h0007, 32'h12345678});
    $display("protected page done");
  endtask

  task automatic t_loss();
    dirty = 1'b1;
    bidx = 12'h063;
    put(100, '{1'b0, 1'b0, 16'h0001, 32'hCAFE0001});
    put(99, '{1'b0, 1'b0, 16'h0002, 32'hCAFE0002});
    run(1'b0, 1'b1, 1'b0, {6'h03, 5'h01, 7'h00}, 2'h1, 100,
        '{1'b0, 1'b0, 16'h0001, 32'hCAFE0001});
    run(1'b0, 1'b1, 1'b0, {6'h03, 5'h00, 7'h00}, 2'h0, 99, ers(1'b0, 16'h0002));
    dirty = 1'b0;
    $display("loss guard done");
  endtask

  task automatic t_wear();
    // threshold itself is not over it
    put(137, '{1'b0, 1'b0, 16'h1001, 32'h0000FFFF});
    put(138, '{1'b0, 1'b0, 16'h1000, 32'h0000FFFF});
    run(1'b0, 1'b0, 1'b0, {6'h04, 5'h05, 7'h00}, 2'h3, 137, ers(1'b0, 16'h1001));
    run(1'b0, 1'b0, 1'b0, {6'h04, 5'h06, 7'h00}, 2'h0, 138, ers(1'b0, 16'h1000));
    $display("write count done");
  endtask

  task automatic t_ecc();
    put(171, '{1'b0, 1'b1, 16'h0002, 32'hDEADBEEF});
    run(1'b0, 1'b0, 1'b0, {6'h05, 5'h06, 7'h00}, 2'h2, 171, ers(1'b0, 16'h0002));
    $display("ecc error done");
  endtask

  task automatic t_spare();
    // spare page of sector zero holds no user data, so it is refused
    put(32, '{1'b0, 1'b0, 16'h0001, 32'h13572468});
    run(1'b0, 1'b0, 1'b1, {6'h00, 5'h02, 7'h00}, 2'h1, 32,
        '{1'b0, 1'b0, 16'h0001, 32'h13572468});
    put(2110, '{1'b0, 1'b0, 16'h0004, 32'h55AA55AA});
    put(2111, '{1'b0, 1'b0, 16'h0009, 32'hFFFFFFFF});
    run(1'b0, 1'b0, 1'b1, {6'h3F, 5'h1F, 7'h00}, 2'h0, 2111, ers(1'b0, 16'h0009));
    pidx = 12'h83E;
    @(posedge clk);
    @(posedge clk);
    #1;
    chk("neighbour", {14'h0, 1'b0, 1'b0, 16'h0004, 32'h55AA55AA}, pk);
    $display("spare page done");
  endtask

  task automatic t_hold();
    logic [1:0] s;
    int         lat;
    put(204, '{1'b0, 1'b0, 16'h0003, 32'h0F0F0F0F});
    u_fab.erase({1'b1, 1'b0, 1'b0, 1'b0, 6'h06, 5'h06, 7'h00}, 5, s, lat);
    chk("held status", 2'h0, s);
    chk("held busy", 1'b0, busy);
    pidx = 12'h0CC;
    @(posedge clk);
    @(posedge clk);
    #1;
    // a relaunch would have counted the write twice
    chk("held record", ers(1'b0, 16'h0003), pk);
    $display("held request done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ceiling well above the hundred or so cycles the scenarios need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("idle", 4'h0, {busy, done, st});
    t_plain();
    t_prot();
    t_loss();
    t_wear();
    t_ecc();
    t_spare();
    t_hold();
    end_of_test();
  end
endmodule // flash_page_erase_test
